// ===== shared/sdadc_cfg.svh
/*
  Constants for the delta-sigma converter sequencer: mode codes, priming
  counts, clock rate and the maximum sample rate for each resolution.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef SDADC_CFG_SVH
`define SDADC_CFG_SVH

// Mode codes on mode_i
`define SDADC_MODE_SINGLE 2'h0
`define SDADC_MODE_MULTI 2'h1
`define SDADC_MODE_CONT 2'h2
`define SDADC_MODE_TURBO 2'h3

// Decimator priming: three conversions, result on the fourth
`define SDADC_PRIME_CONV 3
`define SDADC_PRIME_W 3

// Resolution bounds and turbo threshold, in bits
`define SDADC_RES_MIN 8
`define SDADC_RES_MAX 20
`define SDADC_TURBO_RES 17
`define SDADC_RES_12 12
`define SDADC_RES_16 16

// Clock and maximum sample rates, in Hz and samples per second
`define SDADC_CLK_HZ 10000000
`define SDADC_RATE_20B 187
`define SDADC_RATE_16B 48000
`define SDADC_RATE_12B 192000
`define SDADC_RATE_8B 384000

// Least conversion period in clock cycles, rounded up
`define SDADC_PER_CYC(r) ((`SDADC_CLK_HZ + (r) - 1) / (r))

// Widths of period counter, window count and result
`define SDADC_PER_W 16
`define SDADC_CNT_W 17
`define SDADC_OUT_W 20

`endif

// ===== shared/sdadc_pkg.sv
/*
  Types shared by the converter sequencer and its decimator.
  Assumes sdadc_cfg.svh sits on the include path.
*/
`include "sdadc_cfg.svh"

package sdadc_pkg;

  typedef enum logic [1:0] {
    SDADC_ST_STANDBY,
    SDADC_ST_CONVERT,
    SDADC_ST_HOLD
  } sdadc_state_t;

  typedef logic [1:0] sdadc_mode_t;

  typedef struct packed {
    sdadc_state_t state;
    sdadc_mode_t mode;
    logic turbo_hi;
    logic [`SDADC_PER_W-1:0] per;
    logic [`SDADC_PER_W-1:0] per_cnt;
    logic [`SDADC_PRIME_W-1:0] prime_cnt;
    logic done;
    logic valid;
    logic [`SDADC_OUT_W-1:0] result;
    logic [3:0] mux_prev;
    logic mod_rst;
  } sdadc_seq_t;

  typedef struct packed {
    logic [2:0][`SDADC_CNT_W-1:0] hist;
    logic [`SDADC_CNT_W-1:0] win;
  } sdadc_dec_t;

endpackage

// ===== core/sdadc_decim.sv
/*
  Decimator: counts modulator ones over each conversion period and sums
  the last four period counts into a parallel result.
  Assumes period boundaries and clears come from the sequencer.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_cfg.svh"

module sdadc_decim
  import sdadc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control from sequencer
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic conv_end_i,
  // Modulator bitstream
  input wire logic mod_bit_i,
  // Parallel result, current window included
  output logic [`SDADC_OUT_W-1:0] data_o
);

  sdadc_dec_t r_reg;
  sdadc_dec_t r_next;
  logic [`SDADC_CNT_W-1:0] cur;

  always_comb
  begin
    r_next = r_reg;
    cur = r_reg.win + {{(`SDADC_CNT_W-1){1'b0}}, mod_bit_i & run_i};
    // Output depends on the last four periods
    data_o = `SDADC_OUT_W'(r_reg.hist[0]) + `SDADC_OUT_W'(r_reg.hist[1])
           + `SDADC_OUT_W'(r_reg.hist[2]) + `SDADC_OUT_W'(cur);
    if (run_i)
    begin
      r_next.win = cur;
    end
    if (conv_end_i)
    begin
      r_next.hist = {r_reg.hist[1:0], cur};
      r_next.win = '0;
    end
    // Re-priming throws the history away
    if (clr_i)
    begin
      r_next = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r_reg <= '0;
    end
    else if (ce_i)
    begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// ===== core/sdadc_route.sv
/*
  Digital routing: comparator outputs into two-input lookup tables toward
  the programmable logic block interface, one-hot input multiplexer select
  and a switch group.
  Assumes select and function words are held steady by the controller.
*/
`timescale 1ns/1ns
`default_nettype none

module sdadc_route #(
  parameter int unsigned N_CMP = 4,
  parameter int unsigned N_LUT = 4,
  parameter int unsigned N_MUX = 16,
  parameter int unsigned N_SW = 8,
  parameter int unsigned SEL_W = $clog2(N_CMP),
  parameter int unsigned MUX_W = $clog2(N_MUX)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Comparators and lookup tables
  input wire logic [N_CMP-1:0] cmp_i,
  input wire logic [N_LUT*SEL_W-1:0] lut_sel_a_i,
  input wire logic [N_LUT*SEL_W-1:0] lut_sel_b_i,
  input wire logic [N_LUT*4-1:0] lut_func_i,
  output logic [N_LUT-1:0] lut_o,
  // Multiplexer and switch group
  input wire logic [MUX_W-1:0] mux_sel_i,
  input wire logic mux_en_i,
  input wire logic [N_SW-1:0] sw_req_i,
  output logic [N_MUX-1:0] mux_onehot_o,
  output logic [N_SW-1:0] sw_close_o
);

  typedef struct packed {
    logic [N_LUT-1:0] lut;
    logic [N_MUX-1:0] mux;
    logic [N_SW-1:0] sw;
  } sdadc_route_t;

  sdadc_route_t r_reg;
  sdadc_route_t r_next;

  always_comb
  begin
    logic a;
    logic b;
    a = 1'b0;
    b = 1'b0;
    r_next = r_reg;
    // Any comparator may feed either input of any table
    for (int i = 0; i < N_LUT; i++)
    begin
      a = cmp_i[lut_sel_a_i[i*SEL_W +: SEL_W]];
      b = cmp_i[lut_sel_b_i[i*SEL_W +: SEL_W]];
      r_next.lut[i] = lut_func_i[i*4 + int'({~a, ~b})];
    end
    // Binary select decoded so no two inputs can close together
    r_next.mux = '0;
    if (mux_en_i)
    begin
      r_next.mux[mux_sel_i] = 1'b1;
    end
    r_next.sw = sw_req_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r_reg <= '0;
    end
    else if (ce_i)
    begin
      r_reg <= r_next;
    end
  end

  assign lut_o = r_reg.lut;
  assign mux_onehot_o = r_reg.mux;
  assign sw_close_o = r_reg.sw;

endmodule
`default_nettype wire

// ===== core/sdadc_seq.sv
/*
  Delta-sigma converter sequencer: mode control, conversion period timing,
  decimator priming, result capture and end-of-conversion signalling.
  Assumes all inputs synchronous to clk_i; start and read are pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_cfg.svh"

// How it works
// - Four modes are selectable: single sample, multi sample, continuous and turbo multi sample.
// - A software start pulse or the hardware start input begins a sequence in every mode.
// - A finished conversion sets the done status and end-of-conversion output until a result read.
// - Single sample waits in standby, then runs four conversions and gives the fourth as result.
// - After the single result is read the sequencer returns to standby until the next start.
// - Continuous mode gives its first result after three priming periods, then one per period.
// - Multi sample resets the modulator and re-primes the decimator between samples and restarts itself.
// - Turbo acts like multi sample up to 16 bits; from 17 bits it only resets the modulator per sample.
// - After an input multiplexer change no result is valid before the fourth conversion.
// - Resolution selects the period: 187 sps at 20 bits, 48 k at 16, 192 k at 12, 384 k at 8.
// - The decimator turns the modulator bitstream into parallel results at the chosen rate.
// - End of conversion is set at the end of every result-bearing conversion for interrupt or DMA use.
// - Any comparator may drive either input of any two-input lookup table toward the logic interface.
// - The input multiplexer closes one path at most while the switch group may close several.
module sdadc_seq
  import sdadc_pkg::*;
#(
  parameter int unsigned PER20 = `SDADC_PER_CYC(`SDADC_RATE_20B),
  parameter int unsigned PER16 = `SDADC_PER_CYC(`SDADC_RATE_16B),
  parameter int unsigned PER12 = `SDADC_PER_CYC(`SDADC_RATE_12B),
  parameter int unsigned PER8 = `SDADC_PER_CYC(`SDADC_RATE_8B),
  parameter int unsigned N_CMP = 4,
  parameter int unsigned N_LUT = 4,
  parameter int unsigned N_SW = 8
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  input wire logic [1:0] mode_i,
  input wire logic [4:0] res_i,
  input wire logic start_i,
  input wire logic soc_i,
  input wire logic stop_i,
  input wire logic read_i,
  // Modulator
  input wire logic mod_bit_i,
  output logic mod_rst_o,
  // Results and status
  output logic [`SDADC_OUT_W-1:0] result_o,
  output logic result_valid_o,
  output logic eoc_o,
  output logic status_done_o,
  output logic busy_o,
  output logic standby_o,
  // Input multiplexer and switches
  input wire logic [3:0] mux_sel_i,
  input wire logic mux_en_i,
  input wire logic [N_SW-1:0] sw_req_i,
  output logic [15:0] mux_onehot_o,
  output logic [N_SW-1:0] sw_close_o,
  // Comparator lookup tables
  input wire logic [N_CMP-1:0] cmp_i,
  input wire logic [N_LUT*$clog2(N_CMP)-1:0] lut_sel_a_i,
  input wire logic [N_LUT*$clog2(N_CMP)-1:0] lut_sel_b_i,
  input wire logic [N_LUT*4-1:0] lut_func_i,
  output logic [N_LUT-1:0] lut_o
);

  localparam logic [`SDADC_PRIME_W-1:0] PRIME = `SDADC_PRIME_W'(`SDADC_PRIME_CONV);

  sdadc_seq_t r_reg;
  sdadc_seq_t r_next;
  logic start_ev;
  logic conv_end;
  logic dec_clr;
  logic running;
  logic [`SDADC_OUT_W-1:0] dec_data;
  logic [`SDADC_PER_W-1:0] per_sel;

  // Period from resolution; out-of-range settings clamp to the nearest band
  always_comb
  begin
    if (res_i >= 5'(`SDADC_TURBO_RES))
    begin
      per_sel = `SDADC_PER_W'(PER20);
    end
    else if (res_i > 5'(`SDADC_RES_12))
    begin
      per_sel = `SDADC_PER_W'(PER16);
    end
    else if (res_i > 5'(`SDADC_RES_MIN))
    begin
      per_sel = `SDADC_PER_W'(PER12);
    end
    else
    begin
      per_sel = `SDADC_PER_W'(PER8);
    end
  end

  assign start_ev = start_i | soc_i;
  assign running = (r_reg.state == SDADC_ST_CONVERT);
  assign conv_end = running && (r_reg.per_cnt == r_reg.per - 1'b1);

  always_comb
  begin
    r_next = r_reg;
    r_next.mod_rst = 1'b0;
    dec_clr = 1'b0;
    // Read first so a same-cycle completion still sets done
    if (read_i)
    begin
      r_next.done = 1'b0;
    end
    unique case (r_reg.state)
      SDADC_ST_STANDBY:
      begin
        if (start_ev)
        begin
          r_next.state = SDADC_ST_CONVERT;
        end
      end
      SDADC_ST_CONVERT:
      begin
        r_next.per_cnt = r_reg.per_cnt + 1'b1;
        if (stop_i)
        begin
          r_next.state = SDADC_ST_STANDBY;
        end
        else if (conv_end)
        begin
          r_next.per_cnt = '0;
          if (r_reg.prime_cnt < PRIME)
          begin
            r_next.prime_cnt = r_reg.prime_cnt + 1'b1;
          end
          else
          begin
            // Fourth conversion after priming carries the result
            r_next.result = dec_data;
            r_next.valid = 1'b1;
            r_next.done = 1'b1;
            unique case (r_reg.mode)
              `SDADC_MODE_SINGLE:
              begin
                r_next.state = SDADC_ST_HOLD;
              end
              `SDADC_MODE_CONT:
              begin
                r_next.state = SDADC_ST_CONVERT;
              end
              `SDADC_MODE_MULTI:
              begin
                r_next.prime_cnt = '0;
                r_next.mod_rst = 1'b1;
                dec_clr = 1'b1;
              end
              `SDADC_MODE_TURBO:
              begin
                // High resolution keeps decimator history, only the modulator resets
                r_next.mod_rst = 1'b1;
                if (!r_reg.turbo_hi)
                begin
                  r_next.prime_cnt = '0;
                  dec_clr = 1'b1;
                end
              end
            endcase
          end
        end
      end
      SDADC_ST_HOLD:
      begin
        if (read_i)
        begin
          r_next.state = SDADC_ST_STANDBY;
        end
      end
    endcase
    // Any start, in standby or mid-run, restarts priming from scratch
    if (start_ev && r_reg.state != SDADC_ST_HOLD)
    begin
      r_next.state = SDADC_ST_CONVERT;
      r_next.mode = mode_i;
      r_next.turbo_hi = (res_i >= 5'(`SDADC_TURBO_RES));
      r_next.per = per_sel;
      r_next.per_cnt = '0;
      r_next.prime_cnt = '0;
      r_next.valid = 1'b0;
      r_next.mod_rst = 1'b1;
      dec_clr = 1'b1;
    end
    // Multiplexer change restarts the valid count; history is not cleared
    if (mux_sel_i != r_reg.mux_prev)
    begin
      r_next.mux_prev = mux_sel_i;
      r_next.prime_cnt = '0;
      r_next.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r_reg <= '{state: SDADC_ST_STANDBY, mode: `SDADC_MODE_SINGLE, default: '0};
    end
    else if (ce_i)
    begin
      r_reg <= r_next;
    end
  end

  sdadc_decim u_decim (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(dec_clr),
    .run_i(running),
    .conv_end_i(conv_end),
    .mod_bit_i(mod_bit_i),
    .data_o(dec_data)
  );

  sdadc_route #(
    .N_CMP(N_CMP),
    .N_LUT(N_LUT),
    .N_MUX(16),
    .N_SW(N_SW)
  ) u_route (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cmp_i(cmp_i),
    .lut_sel_a_i(lut_sel_a_i),
    .lut_sel_b_i(lut_sel_b_i),
    .lut_func_i(lut_func_i),
    .lut_o(lut_o),
    .mux_sel_i(mux_sel_i),
    .mux_en_i(mux_en_i),
    .sw_req_i(sw_req_i),
    .mux_onehot_o(mux_onehot_o),
    .sw_close_o(sw_close_o)
  );

  assign result_o = r_reg.result;
  assign result_valid_o = r_reg.valid;
  assign eoc_o = r_reg.done;
  assign status_done_o = r_reg.done;
  assign busy_o = running;
  assign standby_o = (r_reg.state == SDADC_ST_STANDBY);
  assign mod_rst_o = r_reg.mod_rst;

endmodule
`default_nettype wire

// ===== test/sdadc_host_model.sv
/*
  Host-side model: CPU or DMA reader of results and modulator bitstream.
  Assumes eoc_i comes from the sequencer on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module sdadc_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Reader control
  input wire logic eoc_i,
  input wire logic rd_en_i,
  input wire logic [3:0] rd_dly_i,
  // To the sequencer
  output logic read_o,
  output logic mod_bit_o
);
  logic [3:0] cnt_reg;

  // Full-scale input keeps every window sum predictable
  assign mod_bit_o = 1'b1;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_reg <= 4'h0;
      read_o <= 1'b0;
    end
    else
    begin
      read_o <= 1'b0;
      if (!eoc_i || read_o || !rd_en_i)
        cnt_reg <= 4'h0;
      else if (cnt_reg == rd_dly_i)
        read_o <= 1'b1;
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
endmodule

`default_nettype wire

// ===== test/sdadc_seq_chk.sv
/*
  Assertion checker for the converter sequencer top.
  Assumes it is bound into sdadc_seq and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

module sdadc_seq_chk #(
  parameter int unsigned N_SW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  input wire logic start_i,
  input wire logic soc_i,
  input wire logic read_i,
  // Status
  input wire logic eoc_o,
  input wire logic status_done_o,
  input wire logic busy_o,
  input wire logic standby_o,
  input wire logic result_valid_o,
  input wire logic mod_rst_o,
  // Routing
  input wire logic [3:0] mux_sel_i,
  input wire logic mux_en_i,
  input wire logic [N_SW-1:0] sw_req_i,
  input wire logic [15:0] mux_onehot_o,
  input wire logic [N_SW-1:0] sw_close_o
);
  logic hold;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign hold = !busy_o && !standby_o;

  flag_pair_a: assert property (eoc_o == status_done_o)
    else $error("done flags differ");
  eoc_keep_a: assert property (eoc_o && !read_i |=> eoc_o)
    else $error("eoc dropped unread");
  hold_read_a: assert property (ce_i && hold && read_i |=> standby_o && !eoc_o)
    else $error("no standby after read");
  hold_start_a: assert property (hold && !read_i && (start_i || soc_i) |=> !busy_o)
    else $error("start taken in hold");
  start_run_a: assert property (ce_i && standby_o && (start_i || soc_i) |=> busy_o && mod_rst_o ##1 !mod_rst_o)
    else $error("start not taken");
  prime_hold_a: assert property ($rose(busy_o) |-> !result_valid_o [*8])
    else $error("valid during priming");
  mux_drop_a: assert property (ce_i && mux_sel_i != $past(mux_sel_i) |=> !result_valid_o)
    else $error("valid after mux change");
  eoc_valid_a: assert property ($rose(eoc_o) |-> result_valid_o)
    else $error("eoc without result");
  one_path_a: assert property (ce_i |=> mux_onehot_o == ($past(mux_en_i) ? 16'h1 << $past(mux_sel_i) : 16'h0))
    else $error("mux select wrong");
  switch_a: assert property (ce_i |=> sw_close_o == $past(sw_req_i))
    else $error("switch group wrong");
endmodule

bind sdadc_seq sdadc_seq_chk #(.N_SW(N_SW)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(start_i), .soc_i(soc_i),
  .read_i(read_i), .eoc_o(eoc_o), .status_done_o(status_done_o), .busy_o(busy_o),
  .standby_o(standby_o), .result_valid_o(result_valid_o), .mod_rst_o(mod_rst_o),
  .mux_sel_i(mux_sel_i), .mux_en_i(mux_en_i), .sw_req_i(sw_req_i),
  .mux_onehot_o(mux_onehot_o), .sw_close_o(sw_close_o)
);

`default_nettype wire

// ===== test/tb_top.sv
/*
  Self-checking bench for the converter sequencer with a host reader.
  Assumes short conversion periods set through the period parameters.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_cfg.svh"

module tb_top;
  localparam int P20 = 30, P16 = 12, P12 = 8, P8 = 6;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, soc = 1'b0, stop = 1'b0, mux_en = 1'b0, rd_en = 1'b0;
  logic ce = 1'b1;
  logic [7:0] sel_a = 8'h00, sel_b = 8'h01;
  logic [1:0] mode = 2'h0;
  logic [4:0] res = 5'h08;
  logic [3:0] mux_sel = 4'h0, cmp = 4'h0, rd_dly = 4'h1, lut;
  logic [7:0] sw_req = 8'h00, sw_close;
  logic [15:0] func = 16'h0000, onehot;
  logic [19:0] result;
  logic rd, mbit, mrst, valid, eoc, done, busy, idle;
  int errors = 0, checks_done = 0;

  sdadc_seq #(.PER20(P20), .PER16(P16), .PER12(P12), .PER8(P8)) DUT (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .mode_i(mode), .res_i(res), .start_i(start),
    .soc_i(soc), .stop_i(stop), .read_i(rd), .mod_bit_i(mbit), .mod_rst_o(mrst),
    .result_o(result), .result_valid_o(valid), .eoc_o(eoc), .status_done_o(done),
    .busy_o(busy), .standby_o(idle), .mux_sel_i(mux_sel), .mux_en_i(mux_en),
    .sw_req_i(sw_req), .mux_onehot_o(onehot), .sw_close_o(sw_close), .cmp_i(cmp),
    .lut_sel_a_i(sel_a), .lut_sel_b_i(sel_b), .lut_func_i(func), .lut_o(lut)
  );

  sdadc_host_model host (
    .clk_i(clk), .rst_i(rst), .eoc_i(eoc), .rd_en_i(rd_en), .rd_dly_i(rd_dly),
    .read_o(rd), .mod_bit_o(mbit)
  );

  initial
    forever #50 clk = ~clk;

  task ck(input bit ok, input string m);
    checks_done++;
    if (!ok)
    begin
      $display("[FAIL] %0t %s", $time, m);
      errors++;
    end
  endtask

  task go(input logic [1:0] m, input logic [4:0] r, input bit hw);
    @(posedge clk);
    mode <= m;
    res <= r;
    start <= !hw;
    soc <= hw;
    @(posedge clk);
    start <= 1'b0;
    soc <= 1'b0;
    #1;
    ck(busy === 1'b1, "no start");
  endtask

  // Counts edges up to the next rise of end of conversion
  task rise(output int n);
    logic l;
    n = 0;
    do
    begin
      l = eoc;
      @(posedge clk);
      #1;
      n++;
    end
    while (!(eoc === 1'b1 && l !== 1'b1) && n < 4000);
  endtask

  task halt;
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    #1;
    ck(idle === 1'b1 && busy === 1'b0, "stop ignored");
  endtask

  task runs(input logic [1:0] m, input logic [4:0] r, input int first, input int gap, input int rv);
    int n;
    rd_en = 1'b1;
    go(m, r, 1'b0);
    rise(n);
    ck(n == first, "first result");
    repeat (2)
    begin
      rise(n);
      ck(n == gap && busy === 1'b1 && valid === 1'b1, "result spacing");
      ck(mrst === (m != `SDADC_MODE_CONT), "modulator reset");
      if (rv > 0)
        ck(result === 20'(rv), "window sum");
    end
    halt();
  endtask

  task t_reset;
    ck(idle === 1'b1 && busy === 1'b0 && eoc === 1'b0 && valid === 1'b0 && result === 20'h0, "reset");
  endtask

  task t_single;
    int n;
    logic [4:0] rs [4] = '{5'h14, 5'h10, 5'h0c, 5'h08};
    int ps [4] = '{P20, P16, P12, P8};
    for (int i = 0; i < 4; i++)
    begin
      rd_en = 1'b0;
      rd_dly = 4'(3 * i[0]);
      go(`SDADC_MODE_SINGLE, rs[i], i[0]);
      rise(n);
      ck(n == 4 * ps[i] && valid === 1'b1, "single latency");
      repeat (5) @(posedge clk);
      ck(eoc === 1'b1 && done === 1'b1 && busy === 1'b0 && idle === 1'b0, "not held");
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      ck(busy === 1'b0, "start in hold");
      rd_en = 1'b1;
      repeat (6) @(posedge clk);
      ck(idle === 1'b1 && eoc === 1'b0, "no standby");
    end
  endtask

  task t_modes;
    runs(`SDADC_MODE_CONT, 5'h0c, 4 * P12, P12, 4 * P12);
    runs(`SDADC_MODE_MULTI, 5'h08, 4 * P8, 4 * P8, 0);
    runs(`SDADC_MODE_TURBO, 5'h10, 4 * P16, 4 * P16, 0);
    runs(`SDADC_MODE_TURBO, 5'h14, 4 * P20, P20, 4 * P20);
  endtask

  // Enable low for ten edges shifts the first result by ten; reset mid-run clears it
  task t_freeze;
    int n;
    go(`SDADC_MODE_CONT, 5'h08, 1'b0);
    @(posedge clk);
    ce <= 1'b0;
    mux_en <= 1'b1;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    #1;
    ck(busy === 1'b1 && onehot === 16'h0, "not frozen");
    rise(n);
    ck(n == 4 * P8 - 1 && valid === 1'b1 && result === 20'(4 * P8), "freeze timing");
    @(posedge clk);
    rst <= 1'b1;
    mux_en <= 1'b0;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    ck(idle === 1'b1 && busy === 1'b0 && valid === 1'b0 && eoc === 1'b0 && result === 20'h0, "mid reset");
  endtask

  // Input switched only in multi sample mode
  task t_mux;
    int n;
    go(`SDADC_MODE_MULTI, 5'h08, 1'b1);
    rise(n);
    @(posedge clk);
    mux_sel <= 4'h5;
    @(posedge clk);
    #1;
    ck(valid === 1'b0, "valid kept");
    rise(n);
    ck(n <= 6 * P8 && valid === 1'b1, "no result");
    halt();
  endtask

  task t_route;
    logic [3:0] fw [4] = '{4'h1, 4'h6, 4'h3, 4'hc};
    logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      mux_en <= i[0];
      mux_sel <= i[3:0];
      sw_req <= 8'(i * 17);
      @(posedge clk);
      #1;
      ck(onehot === (i[0] ? 16'h1 << i : 16'h0) && sw_close === 8'(i * 17), "routing");
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      cmp <= 4'h1;
      func <= {12'h000, fw[i]};
      @(posedge clk);
      #1;
      ck(lut[0] === ex[i], "lookup");
    end
    // Other comparators on both table inputs, A and not B
    @(posedge clk);
    sel_a <= 8'h02;
    sel_b <= 8'h03;
    cmp <= 4'h4;
    func <= 16'h0002;
    @(posedge clk);
    #1;
    ck(lut[0] === 1'b1, "lookup select");
    @(posedge clk);
    cmp <= 4'h1;
    @(posedge clk);
    #1;
    ck(lut[0] === 1'b0, "lookup select");
  endtask

  task wrap_up;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_single();
    t_modes();
    t_freeze();
    t_mux();
    t_route();
    wrap_up();
  end

  // Whole run needs under a thousand cycles
  initial
  begin
    #(20000 * 100);
    errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
